// ### pkg/synth_pkg.sv
`default_nettype none
package synth_pkg;
    localparam logic [4:0] addr_fixed = 5'h18;
    localparam int dir_pos = 0;
    localparam int kind_pos = 7;
    localparam int pump_pos = 6;
    localparam int test_hi = 5;
    localparam int test_lo = 3;
    localparam int ref_hi = 2;
    localparam int ref_lo = 1;
    localparam int amp_pos = 0;
    localparam logic [2:0] test_normal = 3'h1;
    localparam logic [2:0] test_ref_cnt = 3'h4;
    localparam logic [2:0] test_ref_half = 3'h5;
    localparam logic [2:0] test_phase = 3'h0;
    localparam logic [7:0] control_reset = 8'h8e;
    localparam logic [3:0] band_reset = 4'h0;
    localparam logic [14:0] ratio_reset = 15'h0000;
    localparam logic [2:0] status_ones = 3'h7;
    localparam logic [1:0] ratio_64 = 2'h0;
    localparam logic [1:0] ratio_128 = 2'h1;
    localparam logic [1:0] ratio_80 = 2'h2;
    localparam logic [2:0] bit_last = 3'h7;
    typedef struct packed {
        logic [14:0] divide_ratio;
        logic pump_current_sel;
        logic [2:0] test_mode_sel;
        logic [1:0] ref_div_sel;
        logic tune_amp_off;
        logic [3:0] band_outputs;
    } settings_type;
    typedef struct packed {
        logic ge_01;
        logic ge_04;
        logic le_06;
        logic ge_09;
    } addr_level_type;
    typedef struct packed {
        logic ge_015;
        logic ge_030;
        logic ge_045;
        logic ge_060;
    } adc_level_type;
endpackage
`default_nettype wire

// ### rtl/level_decode.sv
`timescale 1ns/100ps
`default_nettype none
module level_decode
    import synth_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire addr_level_type addr_level,
    input wire adc_level_type adc_level,
    output logic [1:0] addr_select_bits,
    output logic [2:0] level_code
);
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            addr_select_bits <= 2'h1;
        end else if (!addr_level.ge_01) begin
            addr_select_bits <= 2'h0;
        end else if (addr_level.ge_04 && addr_level.le_06) begin
            addr_select_bits <= 2'h2;
        end else if (addr_level.ge_09) begin
            addr_select_bits <= 2'h3;
        end else begin
            addr_select_bits <= 2'h1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level_code <= 3'h0;
        end else if (adc_level.ge_060) begin
            level_code <= 3'h4;
        end else if (adc_level.ge_045) begin
            level_code <= 3'h3;
        end else if (adc_level.ge_030) begin
            level_code <= 3'h2;
        end else if (adc_level.ge_015) begin
            level_code <= 3'h1;
        end else begin
            level_code <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// ### rtl/sync_bits.sv
`timescale 1ns/100ps
`default_nettype none
module sync_bits #(
    parameter int width = 1,
    parameter logic [width-1:0] init_value = '0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] stage;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            stage <= init_value;
            sync_out <= init_value;
        end else begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule
`default_nettype wire

// ### rtl/synth_i2c_control_port.sv
// Operation
// - Address is 11000, two select bits, then direction: 0 write, 1 read.
// - Select bits come from the address pin voltage band.
// - First divider byte: 0 then ratio bits 14..8.
// - Second divider byte carries ratio bits 7..0.
// - Settings apply at the eighth bit of divider pair, control and band bytes, before ack.
// - Control byte leads with 1; next bit picks high or low pump current.
// - Test code 001 normal; 100 routes reference to out4, counter to out2.
// - Test code 101 routes reference to out4, half counter to out2.
// - Test code 000: data vs clock comparator result on check pin.
// - Reference select 11 gives 1/64, 01 gives 1/128, x0 gives 1/80.
// - Low control bit set turns tuning amp off, output low.
// - Status bit 7 is the power-up flag.
// - Status bit 6 is the lock flag.
// - Status bits 5..3 read 1; low bits give five-level input code.
// - After write address, leading 0 means divider, leading 1 control/band.
// - Data bytes continue until stop; latched data survive aborts.
// - Power-up flag sets at power-on, clears after status is read.
// - Band byte low nibble drives band outputs; bit 7 must be 1, bits 6..4 ignored.
`timescale 1ns/100ps
`default_nettype none
module synth_i2c_control_port
    import synth_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire addr_level_type addr_level,
    input wire adc_level_type adc_level,
    input wire logic lock_detect_bit,
    input wire logic ref_div_signal,
    input wire logic main_count_signal,
    input wire logic phase_cmp_result,
    output settings_type settings,
    output logic [1:0] ref_ratio_sel,
    output logic tune_amp_enable,
    output logic [3:0] band_pins,
    output logic phase_test_active,
    output logic phase_cmp_data,
    output logic phase_cmp_ref,
    output logic check_output_pin,
    output logic power_up_flag
);
    typedef enum {
        st_idle,
        st_addr,
        st_addr_ack,
        st_wdata,
        st_wack,
        st_rdata,
        st_rack,
        st_skip
    } bus_state_type;

    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic [1:0] addr_select_bits;
    logic [2:0] level_code;
    bus_state_type state;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic dir_read;
    logic last_control;
    logic [6:0] ratio_high;
    logic high_valid;
    logic [7:0] status_byte;
    logic half_count;
    logic count_prev;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic addr_match;
    logic [7:0] next_shift;
    addr_level_type addr_level_s;
    adc_level_type adc_level_s;
    logic lock_s;
    logic ref_s;
    logic count_s;
    logic cmp_s;

    function automatic logic [1:0] ratio_of(input logic [1:0] sel);
        if (!sel[0]) begin
            ratio_of = ratio_80;
        end else if (sel[1]) begin
            ratio_of = ratio_64;
        end else begin
            ratio_of = ratio_128;
        end
    endfunction

    // Bus lines idle high, so their synchronisers start high: no false edge after reset
    sync_bits #(.width(2), .init_value(2'h3)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({scl_in, sda_in}),
        .sync_out({scl_s, sda_s})
    );

    // Analog comparator flags and loop signals come from other clocks
    sync_bits #(.width(8)) u_sync_levels (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({addr_level, adc_level}),
        .sync_out({addr_level_s, adc_level_s})
    );

    sync_bits #(.width(4)) u_sync_loop (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in({lock_detect_bit, ref_div_signal, main_count_signal, phase_cmp_result}),
        .sync_out({lock_s, ref_s, count_s, cmp_s})
    );

    level_decode u_levels (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .addr_level(addr_level_s),
        .adc_level(adc_level_s),
        .addr_select_bits(addr_select_bits),
        .level_code(level_code)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    // Start and stop are data edges while the clock stays high
    assign start_seen = scl_s && scl_d && sda_d && !sda_s;
    assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
    assign next_shift = {shift[6:0], sda_s};
    assign addr_match = next_shift[7:3] == addr_fixed
        && next_shift[2:1] == addr_select_bits;

    assign status_byte = {power_up_flag, lock_s, status_ones, level_code};

    // Serial engine
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state <= st_idle;
            shift <= 8'h00;
            bit_cnt <= 3'h0;
            dir_read <= 1'b0;
        end else if (start_seen) begin
            state <= st_addr;
            bit_cnt <= 3'h0;
        end else if (stop_seen) begin
            state <= st_idle;
        end else begin
            case (state)
                st_addr, st_wdata: begin
                    if (scl_rise) begin
                        shift <= next_shift;
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == bit_last) begin
                            if (state == st_wdata) begin
                                state <= st_wack;
                            end else if (addr_match) begin
                                dir_read <= next_shift[dir_pos];
                                state <= st_addr_ack;
                            end else begin
                                state <= st_skip;
                            end
                        end
                    end
                end
                st_addr_ack, st_wack: begin
                    if (scl_rise) begin
                        state <= dir_read ? st_rdata : st_wdata;
                        // Status is frozen here so it cannot change mid-byte
                        if (dir_read) begin
                            shift <= status_byte;
                        end
                    end
                end
                st_rdata: begin
                    if (scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == bit_last) begin
                            state <= st_rack;
                        end
                    end
                    if (scl_fall && bit_cnt != 3'h0) begin
                        shift <= {shift[6:0], 1'b1};
                    end
                end
                st_rack: begin
                    if (scl_rise) begin
                        state <= st_skip;
                    end
                end
                st_skip, st_idle: begin
                    state <= state;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end

    // Acknowledge and read data drive, changed while the clock is low and released at start or stop
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sda_oe <= 1'b0;
        end else if (scl_fall) begin
            case (state)
                st_addr_ack, st_wack: begin
                    sda_oe <= 1'b1;
                end
                st_rdata: begin
                    // The shift register moves on this same edge, so look one bit ahead
                    if (bit_cnt == 3'h0) begin
                        sda_oe <= !shift[7];
                    end else begin
                        sda_oe <= !shift[6];
                    end
                end
                default: begin
                    sda_oe <= 1'b0;
                end
            endcase
        end else if (start_seen || stop_seen) begin
            sda_oe <= 1'b0;
        end
    end
    assign sda_out = 1'b0;

    // Byte latching
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            settings.divide_ratio <= ratio_reset;
            {settings.pump_current_sel, settings.test_mode_sel, settings.ref_div_sel,
                settings.tune_amp_off} <= control_reset[6:0];
            settings.band_outputs <= band_reset;
            ratio_high <= 7'h00;
            high_valid <= 1'b0;
            last_control <= 1'b0;
        end else if (start_seen) begin
            high_valid <= 1'b0;
            last_control <= 1'b0;
        end else if (state == st_wdata && scl_rise && bit_cnt == bit_last) begin
            // The low divider byte may lead with 1, so a pending pair outranks the kind bit
            if (high_valid) begin
                settings.divide_ratio <= {ratio_high, next_shift};
                high_valid <= 1'b0;
                last_control <= 1'b0;
            end else if (!next_shift[kind_pos]) begin
                ratio_high <= next_shift[6:0];
                high_valid <= 1'b1;
                last_control <= 1'b0;
            end else if (last_control) begin
                settings.band_outputs <= next_shift[3:0];
                last_control <= 1'b0;
            end else begin
                settings.pump_current_sel <= next_shift[pump_pos];
                settings.test_mode_sel <= next_shift[test_hi:test_lo];
                settings.ref_div_sel <= next_shift[ref_hi:ref_lo];
                settings.tune_amp_off <= next_shift[amp_pos];
                last_control <= 1'b1;
            end
        end
    end

    // Power-up flag clears once the status byte has been sent
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            power_up_flag <= 1'b1;
        end else if (state == st_rack && scl_rise) begin
            power_up_flag <= 1'b0;
        end
    end

    // Half-rate counter output for test routing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_prev <= 1'b0;
            half_count <= 1'b0;
        end else begin
            count_prev <= count_s;
            if (count_s && !count_prev) begin
                half_count <= !half_count;
            end
        end
    end

    // Output routing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            band_pins <= band_reset;
            ref_ratio_sel <= ratio_64;
            tune_amp_enable <= !control_reset[amp_pos];
        end else begin
            ref_ratio_sel <= ratio_of(settings.ref_div_sel);
            tune_amp_enable <= !settings.tune_amp_off;
            case (settings.test_mode_sel)
                test_ref_cnt: begin
                    band_pins <= {ref_s, settings.band_outputs[2],
                        count_s, settings.band_outputs[0]};
                end
                test_ref_half: begin
                    band_pins <= {ref_s, settings.band_outputs[2],
                        half_count, settings.band_outputs[0]};
                end
                default: begin
                    band_pins <= settings.band_outputs;
                end
            endcase
        end
    end

    // Phase comparator test routing
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_test_active <= 1'b0;
            phase_cmp_data <= 1'b0;
            phase_cmp_ref <= 1'b0;
            check_output_pin <= 1'b0;
        end else begin
            phase_test_active <= settings.test_mode_sel == test_phase;
            phase_cmp_data <= sda_s;
            phase_cmp_ref <= scl_s;
            check_output_pin <= settings.test_mode_sel == test_phase && cmp_s;
        end
    end
endmodule
`default_nettype wire

// ### tb/i2c_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_master (
    input wire logic core_clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        @(posedge core_clk);
        scl <= c;
        sda_drv <= d;
    endtask
    task automatic start();
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b0, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
    endtask
    // One bit in eight clocks: low five, high three, sampled late in high
    task automatic bit_cycle(input logic d, output logic q);
        for (int j = 0; j < 8; j++) begin
            step(j > 3 && j < 7, d);
            if (j == 6) begin
                #1 q = sda_line;
            end
        end
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], q);
        bit_cycle(1'b1, q);
        ack = !q;
    endtask
    task automatic recv(output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
        bit_cycle(1'b1, q);
    endtask
endmodule
`default_nettype wire

// ### tb/synth_i2c_control_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module synth_i2c_control_port_assertions
    import synth_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire addr_level_type addr_level,
    input wire adc_level_type adc_level,
    input wire logic lock_detect_bit,
    input wire logic ref_div_signal,
    input wire logic main_count_signal,
    input wire logic phase_cmp_result,
    input wire settings_type settings,
    input wire logic [1:0] ref_ratio_sel,
    input wire logic tune_amp_enable,
    input wire logic [3:0] band_pins,
    input wire logic phase_test_active,
    input wire logic phase_cmp_data,
    input wire logic phase_cmp_ref,
    input wire logic check_output_pin,
    input wire logic power_up_flag
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Acknowledge follows a latch and then stands
    sequence ack_soon;
        ##[1:8] $rose(sda_oe);
    endsequence
    sequence ack_stands;
        sda_oe [*4];
    endsequence
    ratio_latch_a: assert property ($changed(settings.divide_ratio) |-> ack_soon)
        else $error("divide ratio changed away from a byte acknowledge");
    ack_hold_a: assert property ($rose(sda_oe) |=> ack_stands)
        else $error("data line pull released too early");
    por_hold_a: assert property (!$rose(power_up_flag))
        else $error("power-up flag set outside reset");
    por_clear_a: assert property ($fell(power_up_flag) |-> $past(scl_in, 3) && $past(sda_in, 3))
        else $error("power-up flag cleared outside the status acknowledge slot");
    amp_follow_a: assert property ($stable(settings) |-> tune_amp_enable == !settings.tune_amp_off)
        else $error("tuning amplifier enable wrong");
    ratio_map_a: assert property ($stable(settings) |-> ref_ratio_sel == (settings.ref_div_sel[0] ?
        (settings.ref_div_sel[1] ? ratio_64 : ratio_128) : ratio_80))
        else $error("reference ratio select wrong");
    band_normal_a: assert property (settings.test_mode_sel == test_normal && $stable(settings)
        |-> band_pins == settings.band_outputs)
        else $error("band pins do not follow band byte");
    phase_mode_a: assert property ($stable(settings)
        |-> phase_test_active == (settings.test_mode_sel == test_phase))
        else $error("phase test mode flag wrong");
endmodule
bind synth_i2c_control_port synth_i2c_control_port_assertions
    u_synth_i2c_control_port_assertions (.*);
`default_nettype wire

// ### tb/synth_i2c_control_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module synth_i2c_control_port_test
    import synth_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic scl, sda_drv, sda_oe, sda_out, sda_line, scl_in, sda_in;
    addr_level_type addr_level = 4'h2;
    adc_level_type adc_level = 4'h0;
    logic lock_detect_bit = 1'b0, ref_div_signal = 1'b0;
    logic main_count_signal = 1'b0, phase_cmp_result = 1'b0;
    settings_type settings;
    logic [1:0] ref_ratio_sel;
    logic [1:0] cur_sel = 2'h0;
    logic tune_amp_enable, phase_test_active, phase_cmp_data, phase_cmp_ref;
    logic check_output_pin, power_up_flag;
    logic [3:0] band_pins;
    logic [3:0] alv [4] = '{4'h2, 4'he, 4'hd, 4'ha};
    logic [1:0] asel [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int err_count = 0, checks_done = 0;
    // Open-drain data line with pull-up
    assign sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    assign sda_in = sda_line;
    assign scl_in = scl;
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    synth_i2c_control_port u_synth_i2c_control_port (.*);
    i2c_bus_master u_i2c_bus_master (
        .core_clk(core_clk),
        .sda_line(sda_line),
        .scl(scl),
        .sda_drv(sda_drv)
    );
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [7:0] adr(input logic rd);
        return {addr_fixed, cur_sel, rd};
    endfunction
    task automatic wr(input logic [7:0] q[$], input logic exp_ack);
        logic ack;
        u_i2c_bus_master.start();
        foreach (q[i]) begin
            u_i2c_bus_master.send(q[i], ack);
            check("ack", 16'(exp_ack), 16'(ack));
        end
        u_i2c_bus_master.stop();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic t_reset();
        check("ratio", 16'(ratio_reset), 16'(settings.divide_ratio));
        check("ref sel", 16'(ratio_64), 16'(ref_ratio_sel));
        check("amp", 16'h1, 16'(tune_amp_enable));
        check("bands", 16'(band_reset), 16'(band_pins));
        check("por", 16'h1, 16'(power_up_flag));
        check("phase off", 16'h0, 16'(phase_test_active));
        $display("reset test done");
    endtask
    task automatic t_status();
        logic [7:0] st;
        logic ack;
        for (int k = 0; k < 5; k++) begin
            @(posedge core_clk);
            addr_level <= alv[k % 4];
            adc_level <= 4'(4'hf << (4 - k));
            lock_detect_bit <= k[0];
            cur_sel <= asel[k % 4];
            repeat (8) @(posedge core_clk);
            u_i2c_bus_master.start();
            u_i2c_bus_master.send(adr(1'b1), ack);
            check("read ack", 16'h1, 16'(ack));
            u_i2c_bus_master.recv(st);
            u_i2c_bus_master.stop();
            repeat (4) @(posedge core_clk);
            check("status", {8'h0, k == 0, k[0], status_ones, k[2:0]}, 16'(st));
        end
        check("por", 16'h0, 16'(power_up_flag));
        $display("status test done");
    endtask
    task automatic t_divider();
        wr('{adr(1'b0), 8'h7f, 8'hff, 8'h05}, 1'b1);
        check("ratio", 16'h7fff, 16'(settings.divide_ratio));
        wr('{adr(1'b0), 8'h2a}, 1'b1);
        check("ratio", 16'h7fff, 16'(settings.divide_ratio));
        wr('{adr(1'b0), 8'h2a, 8'h5c}, 1'b1);
        check("ratio", 16'h2a5c, 16'(settings.divide_ratio));
        $display("divider test done");
    endtask
    task automatic t_control();
        logic [7:0] c, b;
        for (int i = 0; i < 4; i++) begin
            c = {1'b1, i[0], test_normal, i[1:0], i[1]};
            b = {4'hf, 4'(i * 4 + 5)};
            wr('{adr(1'b0), c, b}, 1'b1);
            check("pump", 16'(i[0]), 16'(settings.pump_current_sel));
            check("ref sel", i[0] ? (i[1] ? 16'(ratio_64) : 16'(ratio_128)) : 16'(ratio_80),
                16'(ref_ratio_sel));
            check("amp", 16'(!i[1]), 16'(tune_amp_enable));
            check("bands", 16'(b[3:0]), 16'(band_pins));
        end
        $display("control test done");
    endtask
    task automatic t_test();
        int n;
        logic last;
        wr('{adr(1'b0), 8'ha6}, 1'b1);
        for (int v = 0; v < 2; v++) begin
            @(posedge core_clk);
            ref_div_signal <= v[0];
            main_count_signal <= !v[0];
            repeat (6) @(posedge core_clk);
            check("ref out", 16'(v[0]), 16'(band_pins[3]));
            check("cnt out", 16'(!v[0]), 16'(band_pins[1]));
        end
        wr('{adr(1'b0), 8'hae}, 1'b1);
        n = 0;
        last = band_pins[1];
        for (int t = 0; t < 48; t++) begin
            @(posedge core_clk);
            if (t % 4 == 0 && t < 32) begin
                main_count_signal <= !main_count_signal;
            end
            @(negedge core_clk);
            if (band_pins[1] !== last) begin
                n++;
            end
            last = band_pins[1];
        end
        check("half toggles", 16'h4, 16'(n));
        check("ref out", 16'h1, 16'(band_pins[3]));
        wr('{adr(1'b0), 8'h86}, 1'b1);
        for (int v = 1; v >= 0; v--) begin
            @(posedge core_clk);
            phase_cmp_result <= v[0];
            repeat (6) @(posedge core_clk);
            check("check pin", 16'(v[0]), 16'(check_output_pin));
        end
        check("phase on", 16'h1, 16'(phase_test_active));
        check("cmp inputs", 16'h3, 16'({phase_cmp_data, phase_cmp_ref}));
        wr('{adr(1'b0), 8'h8e}, 1'b1);
        check("phase off", 16'h0, 16'(phase_test_active));
        $display("test mode test done");
    endtask
    task automatic t_refuse();
        wr('{{addr_fixed, cur_sel ^ 2'h1, 1'b0}, 8'h01, 8'h23}, 1'b0);
        check("ratio", 16'h2a5c, 16'(settings.divide_ratio));
        $display("refusal test done");
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge core_clk);
        err_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset();
        t_status();
        t_divider();
        t_control();
        t_test();
        t_refuse();
        results();
    end
endmodule
`default_nettype wire
